// ---- verilog/sdbo_pkg.sv ----
// Purpose: Shared constants, types and helpers of the burst sequencer.
// Assumes: One 20 MHz clock, synchronous active-low reset.
// Notes: Mode word layout matches the packed mode struct bit for bit.
// Behaviour
// - Mode order bit picks sequential or interleaved.
// - Sequential steps up, wraps in aligned block.
// - Interleaved column is start XOR beat count.
// - Length two: bits 8..1 block, bit 0 start.
// - Length four: bits 8..2 block, 1..0 start.
// - Length eight: bits 8..3 block, 2..0 start.
// - Full page: 512 columns, sequential only.
// - Length one: single column, order bit ignored.
// - Read latency is two or three clocks.
// - Data driven after n+m-1, valid by n+m.
// - Operating mode zero is normal operation.
// - Write mode bit forces single-location writes.
// - Deselected: no new command, bursts continue.
// - No-operation registers nothing, bursts continue.
// - Mode fields: length, order, latency, mode, write.
// - Mode held until loaded again.
package sdbo_pkg;
   localparam int COL_W = 9;
   localparam int ADDR_W = 12;
   localparam int MODE_W = 10;
   localparam int IDX_W = 10;
   localparam int PAGE_COLS = 512;
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;
   localparam logic [2:0] LAT_TWO = 3'h2;
   localparam logic [1:0] OPM_NORMAL = 2'h0;
   localparam logic [9:0] MODE_RESET = 10'h020;
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam int STAT_BUSY = 0;
   localparam int STAT_WR = 1;
   localparam int STAT_IDX_LSB = 4;
   localparam int STAT_COL_LSB = 16;

   typedef struct packed {
      logic wsingle;
      logic [1:0] opm;
      logic [2:0] lat;
      logic order;
      logic [2:0] bl;
   } sdbo_mode_type;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
   } sdbo_cmd_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [COL_W-1:0] col;
   } sdbo_acc_type;

   typedef struct packed {
      logic oe;
      logic [COL_W-1:0] col;
   } sdbo_rd_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } sdbo_wb_req_type;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } sdbo_wb_rsp_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_BURST = 2'h1
   } sdbo_state_type;

   // Reserved length codes behave as length one.
   function automatic logic [COL_W-1:0] sdbo_mask(input logic [2:0] bl);
      case (bl)
         BL_2: sdbo_mask = 9'h001;
         BL_4: sdbo_mask = 9'h003;
         BL_8: sdbo_mask = 9'h007;
         BL_PAGE: sdbo_mask = 9'h1FF;
         default: sdbo_mask = 9'h000;
      endcase
   endfunction

   function automatic logic [IDX_W-1:0] sdbo_beats(input logic [2:0] bl);
      sdbo_beats = {1'b0, sdbo_mask(bl)} + 10'h001;
   endfunction
endpackage

// ---- verilog/sdbo_col_gen.sv ----
// Purpose: Column of one beat from start column, beat index and mode.
// Assumes: Index counts from zero within the burst.
// Notes: Purely combinational.
`timescale 1ns/1ns
`default_nettype none
module sdbo_col_gen
   import sdbo_pkg::*;
(
   input wire logic [sdbo_pkg::COL_W-1:0] start,
   input wire logic [sdbo_pkg::IDX_W-1:0] idx,
   input wire logic [2:0] bl,
   input wire logic order,
   output logic [sdbo_pkg::COL_W-1:0] col
);
   always_comb begin
      logic [COL_W-1:0] m;
      logic [COL_W-1:0] low;
      m = sdbo_mask(bl);
      low = '0;
      // Full page never interleaves; length one has an empty mask.
      if (order && bl != BL_PAGE) begin
         low = start ^ idx[COL_W-1:0];
      end else begin
         low = start + idx[COL_W-1:0];
      end
      col = (start & ~m) | (low & m);
   end
endmodule // sdbo_col_gen
`default_nettype wire

// ---- verilog/sdbo_lat_pipe.sv ----
// Purpose: Delays read beats to the output by the programmed latency.
// Assumes: Beat enters one edge after the read was registered.
// Notes: Output is registered so oe rises right after edge n+m-1.
`timescale 1ns/1ns
`default_nettype none
module sdbo_lat_pipe
   import sdbo_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire sdbo_pkg::sdbo_acc_type beat,
   input wire logic lat2,
   output sdbo_pkg::sdbo_rd_type rd
);
   typedef struct packed {
      sdbo_rd_type s1;
      sdbo_rd_type out;
   } sdbo_pipe_type;

   sdbo_pipe_type st_r;
   sdbo_pipe_type st_nxt;

   always_comb begin
      sdbo_rd_type in;
      in.oe = beat.valid & ~beat.write;
      in.col = beat.col;
      st_nxt.s1 = in;
      st_nxt.out = lat2 ? in : st_r.s1;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd = st_r.out;
endmodule // sdbo_lat_pipe
`default_nettype wire

// ---- verilog/sdbo_seq.sv ----
// Purpose: Command decode, mode hold and burst column sequencing.
// Assumes: Command inputs come from logic on the same clock.
// Notes: Registers reached over classic Wishbone.
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sdbo_seq
   import sdbo_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire sdbo_pkg::sdbo_cmd_type cmd_i,
   input wire sdbo_pkg::sdbo_wb_req_type wb_i,
   output sdbo_pkg::sdbo_wb_rsp_type wb_o,
   output sdbo_pkg::sdbo_acc_type acc_o,
   output sdbo_pkg::sdbo_rd_type rd_o,
   output logic [sdbo_pkg::MODE_W-1:0] mode_o
);
   typedef struct packed {
      sdbo_state_type st;
      sdbo_mode_type mode;
      logic [2:0] bl;
      logic order;
      logic wr;
      logic [COL_W-1:0] start;
      logic [IDX_W-1:0] idx;
      sdbo_acc_type acc;
      sdbo_wb_rsp_type rsp;
   } sdbo_seq_type;

   sdbo_seq_type st_r;
   sdbo_seq_type st_nxt;
   logic sel;
   logic is_nop;
   logic is_rd;
   logic is_wr;
   logic is_lmr;
   logic go;
   logic wb_hit;
   logic [COL_W-1:0] gen_col;
   logic [2:0] cmd_bl;

   // A raised chip select blocks every command; nothing below needs
   // to stop a burst for it, which keeps the burst running.
   assign sel = ~cmd_i.cs_n;
   assign is_nop = sel & cmd_i.ras_n & cmd_i.cas_n & cmd_i.we_n;
   assign is_rd = sel & cmd_i.ras_n & ~cmd_i.cas_n & cmd_i.we_n;
   assign is_wr = sel & cmd_i.ras_n & ~cmd_i.cas_n & ~cmd_i.we_n;
   assign is_lmr = sel & ~cmd_i.ras_n & ~cmd_i.cas_n & ~cmd_i.we_n;
   // Reserved or test operating modes do not start accesses.
   assign go = (is_rd | is_wr) & (st_r.mode.opm == OPM_NORMAL);
   assign wb_hit = wb_i.cyc & wb_i.stb;
   assign cmd_bl = (is_wr & st_r.mode.wsingle) ? BL_1 : st_r.mode.bl;

   sdbo_col_gen u_col (
      .start(st_r.start),
      .idx(st_r.idx),
      .bl(st_r.bl),
      .order(st_r.order),
      .col(gen_col)
   );

   sdbo_lat_pipe u_pipe (
      .clock(clock),
      .rst_n(rst_n),
      .beat(st_r.acc),
      .lat2(st_r.mode.lat == LAT_TWO),
      .rd(rd_o)
   );

   always_comb begin
      logic [MODE_W-1:0] mw;
      logic [IDX_W-1:0] nidx;
      st_nxt = st_r;
      mw = st_r.mode;
      nidx = st_r.idx + 10'h001;
      st_nxt.acc.valid = 1'b0;

      // Bus writes land at the edge that samples ack, by byte lane.
      if (wb_hit && wb_i.we && st_r.rsp.ack && wb_i.adr == REG_MODE) begin
         if (wb_i.sel[0]) begin
            mw[7:0] = wb_i.dat[7:0];
         end
         if (wb_i.sel[1]) begin
            mw[9:8] = wb_i.dat[9:8];
         end
      end
      // A pin load in the same cycle outranks a bus write.
      if (is_lmr) begin
         mw = cmd_i.addr[MODE_W-1:0];
      end
      st_nxt.mode = mw;

      if (go) begin
         st_nxt.start = cmd_i.addr[COL_W-1:0];
         st_nxt.bl = cmd_bl;
         st_nxt.order = st_r.mode.order;
         st_nxt.wr = is_wr;
         st_nxt.idx = 10'h001;
         st_nxt.acc.valid = 1'b1;
         st_nxt.acc.write = is_wr;
         st_nxt.acc.col = cmd_i.addr[COL_W-1:0];
         st_nxt.st = (sdbo_beats(cmd_bl) > 10'h001) ? ST_BURST : ST_IDLE;
      end else begin
         case (st_r.st)
            ST_IDLE: begin
               st_nxt.st = ST_IDLE;
            end
            ST_BURST: begin
               st_nxt.acc.valid = 1'b1;
               st_nxt.acc.write = st_r.wr;
               st_nxt.acc.col = gen_col;
               st_nxt.idx = nidx;
               if (nidx == sdbo_beats(st_r.bl)) begin
                  st_nxt.st = ST_IDLE;
               end
            end
            default: begin
               st_nxt.st = ST_IDLE;
            end
         endcase
      end

      st_nxt.rsp.ack = wb_hit & ~st_r.rsp.ack;
      st_nxt.rsp.dat = 32'h00000000;
      if (wb_hit && !st_r.rsp.ack && !wb_i.we) begin
         case (wb_i.adr)
            REG_MODE: begin
               st_nxt.rsp.dat[MODE_W-1:0] = st_r.mode;
            end
            REG_STATUS: begin
               st_nxt.rsp.dat[STAT_BUSY] = (st_r.st == ST_BURST);
               st_nxt.rsp.dat[STAT_WR] = st_r.wr;
               st_nxt.rsp.dat[STAT_IDX_LSB +: IDX_W] = st_r.idx;
               st_nxt.rsp.dat[STAT_COL_LSB +: COL_W] = st_r.acc.col;
            end
            default: begin
               st_nxt.rsp.dat = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.mode <= MODE_RESET;
         st_r.st <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wb_o = st_r.rsp;
   assign acc_o = st_r.acc;
   assign mode_o = st_r.mode;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   seq_step_a: assert property (
      acc_o.valid && !st_r.acc.write && st_r.st == ST_BURST && !go &&
      !st_r.order && st_r.bl == BL_8 |=>
      acc_o.col[2:0] == 3'($past(acc_o.col[2:0]) + 3'h1) &&
      acc_o.col[8:3] == $past(acc_o.col[8:3]))
      else $error("sequential step or wrap wrong");

   inter_xor_a: assert property (
      st_r.st == ST_BURST && !go && st_r.order && st_r.bl == BL_4 |=>
      acc_o.col[1:0] == ($past(st_r.start[1:0]) ^ $past(st_r.idx[1:0])))
      else $error("interleaved column wrong");

   block_keep_a: assert property (
      st_r.st == ST_BURST && !go |=>
      (acc_o.col & ~sdbo_mask($past(st_r.bl))) ==
      ($past(st_r.start) & ~sdbo_mask($past(st_r.bl))))
      else $error("burst left its block");

   burst_len_a: assert property (
      is_rd && go && st_r.mode.bl == BL_4 && !st_r.mode.wsingle |->
      ##1 acc_o.valid [*4])
      else $error("length four burst short");

   // A bus write at the read edge would change the latency the pipe uses.
   lat_two_a: assert property (
      is_rd && go && st_r.mode.lat == LAT_TWO && !(wb_hit && wb_i.we)
      ##1 !is_lmr |->
      ##1 rd_o.oe && rd_o.col == $past(cmd_i.addr[COL_W-1:0], 2))
      else $error("latency two data late");

   // The pipe picks its tap one edge later, so both edges must keep the mode.
   lat_three_a: assert property (
      is_rd && go && st_r.mode.lat != LAT_TWO && !(wb_hit && wb_i.we)
      ##1 !is_lmr && !(wb_hit && wb_i.we) |->
      ##2 rd_o.oe && rd_o.col == $past(cmd_i.addr[COL_W-1:0], 3))
      else $error("latency three data wrong");

   wr_no_read_a: assert property (
      acc_o.valid && acc_o.write && st_r.mode.lat == LAT_TWO |=> !rd_o.oe)
      else $error("write beat drove read data");

   single_wr_a: assert property (
      is_wr && go && st_r.mode.wsingle ##1 !go |-> ##1 !acc_o.valid)
      else $error("single write ran a burst");

   idle_cmd_a: assert property (
      (!sel || is_nop) && st_r.st == ST_BURST &&
      st_r.idx < 10'(sdbo_beats(st_r.bl) - 10'h001) |=>
      st_r.st == ST_BURST && acc_o.valid)
      else $error("idle command disturbed burst");

   nop_idle_a: assert property (
      st_r.st == ST_IDLE && (!sel || is_nop) |=> !acc_o.valid)
      else $error("idle command started a beat");

   mode_hold_a: assert property (
      !is_lmr && !(wb_hit && wb_i.we) |=> $stable(mode_o))
      else $error("mode changed without load");

   page_len_a: assert property (
      st_r.st == ST_BURST && st_r.bl == BL_PAGE |->
      st_r.idx < 10'(PAGE_COLS))
      else $error("page burst overran");

   // The order bit may be set; a page burst must still count upward.
   page_seq_a: assert property (
      acc_o.valid && st_r.st == ST_BURST && !go && st_r.bl == BL_PAGE |=>
      acc_o.col == 9'($past(acc_o.col) + 9'h001))
      else $error("page burst not sequential");
endmodule // sdbo_seq
`default_nettype wire

// ---- testbench/sdbo_ctl_model.sv ----
// Purpose: Memory controller model that drives the command pins.
// Assumes: Commands launch just after a rising edge, one cycle each.
// Notes: Deselected pins look like a mode load, which must not be taken.
`timescale 1ns/1ns
`default_nettype none
module sdbo_ctl_model
   import sdbo_pkg::*;
(
   input wire logic clock,
   output sdbo_pkg::sdbo_cmd_type cmd
);
   logic [11:0] last_a = 12'h000;
   initial cmd = '{1'b1, 1'b0, 1'b0, 1'b0, 12'hFFF};
   // The inverted address stops a stale value from passing for a held one.
   task automatic idle();
      cmd <= '{1'b1, 1'b0, 1'b0, 1'b0, ~last_a};
   endtask
   task automatic nop();
      cmd <= '{1'b0, 1'b1, 1'b1, 1'b1, ~last_a};
   endtask
   task automatic send(input logic [3:0] c, input logic [11:0] a);
      @(posedge clock);
      cmd <= '{c[3], c[2], c[1], c[0], a};
      last_a = a;
      @(posedge clock);
      idle();
   endtask
   // Only normal operation is loaded; both latencies suit this clock.
   task automatic load(input logic [9:0] m);
      send(4'h0, {2'b00, m[9], 2'b00, m[6:0]});
   endtask
endmodule // sdbo_ctl_model
`default_nettype wire

// ---- testbench/test_sdram_burst_order_and_read_latency.sv ----
// Purpose: Self-checking bench of burst order, latency and mode access.
// Assumes: Controller model owns the command pins.
// Notes: Read data is stood in for by the column of each read beat.
`timescale 1ns/1ns
`default_nettype none
module test_sdram_burst_order_and_read_latency;
   import sdbo_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   sdbo_cmd_type cmd;
   sdbo_wb_req_type wb_i = '0;
   sdbo_wb_rsp_type wb_o;
   sdbo_acc_type acc_o;
   sdbo_rd_type rd_o;
   logic [MODE_W-1:0] mode_o;
   int n_fail = 0;
   int checks = 0;
   int tick = 0;
   always #25 clock = ~clock;
   sdbo_ctl_model ctl (.clock(clock), .cmd(cmd));
   sdbo_seq dut (.clock(clock), .rst_n(rst_n), .cmd_i(cmd), .wb_i(wb_i),
      .wb_o(wb_o), .acc_o(acc_o), .rd_o(rd_o), .mode_o(mode_o));
   task automatic results();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      tick <= tick + 1;
      if (tick == 30000) begin
         n_fail++;
         results();
      end
   end
   task automatic chk(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr,
         input logic [3:0] sel, input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      wb_i <= '{1'b1, 1'b1, we, adr, sel, d};
      do @(posedge clock); while (wb_o.ack !== 1'b1);
      q = wb_o.dat;
      wb_i <= '0;
   endtask
   function automatic logic [8:0] ecol(input logic [2:0] bl, input logic o,
         input logic [8:0] s, input logic [8:0] i);
      logic [8:0] m;
      logic [8:0] low;
      m = (bl == 3'h1) ? 9'h001 : (bl == 3'h2) ? 9'h003 :
         (bl == 3'h3) ? 9'h007 : (bl == 3'h7) ? 9'h1FF : 9'h000;
      low = (o && bl != 3'h7) ? (s ^ i) : (s + i);
      return (s & ~m) | (low & m);
   endfunction
   task automatic bus_test();
      logic [31:0] q;
      wb(1'b0, REG_MODE, 4'hF, 32'h0, q);
      chk("mode reset", q[15:0], 16'h0020);
      wb(1'b1, REG_MODE, 4'h1, 32'h232, q);
      wb(1'b0, REG_MODE, 4'hF, 32'h0, q);
      chk("mode low byte", q[15:0], 16'h0032);
      wb(1'b1, REG_MODE, 4'h3, 32'h232, q);
      wb(1'b0, REG_MODE, 4'hF, 32'h0, q);
      chk("mode word", q[15:0], 16'h0232);
      chk("mode out", mode_o, 16'h0232);
      wb(1'b0, 8'h08, 4'hF, 32'h0, q);
      chk("unmapped", q[15:0], 16'h0000);
      $display("bus test done");
   endtask
   // Misuse on purpose over the bus: a reserved operating mode must block.
   task automatic opm_test();
      logic [31:0] q;
      wb(1'b1, REG_MODE, 4'h3, 32'h000000A2, q);
      ctl.send(4'h5, 12'h010);
      repeat (4) begin
         #1;
         chk("blocked beat", acc_o.valid, 1'b0);
         chk("blocked read", rd_o.oe, 1'b0);
         @(posedge clock);
      end
      ctl.send(4'h4, 12'h011);
      #1;
      chk("blocked write", acc_o.valid, 1'b0);
      $display("operating mode test done");
   endtask
   task automatic burst(input logic [2:0] bl, input logic o, input logic l3,
         input logic ws, input logic wr, input logic [8:0] s, input logic nm);
      int n;
      int m;
      int k;
      logic [9:0] md;
      logic [31:0] q;
      n = (bl == 3'h7) ? 512 : (bl inside {3'h1, 3'h2, 3'h3}) ? (1 << bl) : 1;
      if (wr && ws)
         n = 1;
      m = l3 ? 3 : 2;
      md = {ws, 2'b00, l3 ? 3'h3 : 3'h2, o, bl};
      ctl.load(md);
      ctl.send(wr ? 4'h4 : 4'h5, {3'h0, s});
      for (int i = 0; i < n + m; i++) begin
         #1;
         k = i - m + 1;
         chk("beat valid", acc_o.valid, i < n);
         if (i < n) begin
            chk("beat col", acc_o.col, ecol(bl, o, s, 9'(i)));
            chk("beat dir", acc_o.write, wr);
         end
         chk("read out", rd_o.oe, !wr && k >= 0 && k < n);
         if (!wr && k >= 0 && k < n)
            chk("read col", rd_o.col, ecol(bl, o, s, 9'(k)));
         @(posedge clock);
         if (nm && i == 0)
            ctl.nop();
         if (nm && i == 1)
            ctl.idle();
      end
      chk("mode held", mode_o, md);
      wb(1'b0, REG_STATUS, 4'hF, 32'h00000000, q);
      chk("status word", q[15:0], {2'b00, 10'(n), 2'b00, wr, 1'b0});
      chk("status col", {7'h00, q[24:16]}, {7'h00, ecol(bl, o, s, 9'(n - 1))});
      $display("burst test done");
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      bus_test();
      opm_test();
      burst(3'h2, 1'b0, 1'b0, 1'b0, 1'b0, 9'h005, 1'b0);
      burst(3'h2, 1'b1, 1'b0, 1'b0, 1'b0, 9'h005, 1'b0);
      burst(3'h3, 1'b1, 1'b1, 1'b0, 1'b0, 9'h0E5, 1'b0);
      burst(3'h3, 1'b0, 1'b1, 1'b0, 1'b0, 9'h14F, 1'b1);
      burst(3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 9'h0FF, 1'b0);
      burst(3'h1, 1'b1, 1'b1, 1'b0, 1'b0, 9'h1FE, 1'b0);
      burst(3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 9'h123, 1'b0);
      burst(3'h7, 1'b1, 1'b0, 1'b0, 1'b0, 9'h1FE, 1'b0);
      burst(3'h3, 1'b0, 1'b0, 1'b1, 1'b1, 9'h00B, 1'b0);
      burst(3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 9'h00B, 1'b0);
      burst(3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 9'h0AA, 1'b1);
      results();
   end
endmodule // test_sdram_burst_order_and_read_latency
`default_nettype wire
